// ### common/memmap_pkg.sv
package memmap_pkg;
  localparam int PC_W = 13;
  localparam int PWORD_W = 14;
  localparam int DADDR_W = 9;
  localparam int OFS_W = 7;
  localparam int BANK_W = 2;
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0] INT_VEC = 13'h0004;
  localparam logic [OFS_W-1:0] OFS_INDIRECT = 7'h00;
  localparam logic [OFS_W-1:0] OFS_STATUS = 7'h03;
  localparam logic [OFS_W-1:0] OFS_POINTER = 7'h04;
  localparam logic [OFS_W-1:0] OFS_TIMER = 7'h01;
  localparam logic [OFS_W-1:0] OFS_PCL = 7'h02;
  localparam logic [OFS_W-1:0] OFS_PCLATH = 7'h0A;
  localparam logic [OFS_W-1:0] OFS_INTCON = 7'h0B;
  localparam logic [DADDR_W-1:0] B3_OPTION = 9'h181;
  localparam logic [DADDR_W-1:0] B1_OPTION = 9'h081;
  localparam logic [OFS_W-1:0] SFR_LAST = 7'h1F;
  localparam logic [OFS_W-1:0] SHARED_LO = 7'h70;
  localparam logic [DADDR_W-1:0] B3_GAP_LO = 9'h18D;
  localparam logic [DADDR_W-1:0] B3_GAP_HI = 9'h195;
  localparam logic [DADDR_W-1:0] B2_SFR_END = 9'h114;
  localparam int STATUS_LO_BIT = 5;
  localparam int STATUS_HI_BIT = 6;
  localparam int RAM_DEPTH = 363;
  localparam int RAM_AW = 9;
  localparam logic [RAM_AW-1:0] RAM_B0 = 9'h000;
  localparam logic [RAM_AW-1:0] RAM_B1 = 9'h060;
  localparam logic [RAM_AW-1:0] RAM_B2 = 9'h0B0;
  localparam logic [RAM_AW-1:0] RAM_B2G = 9'h100;
  localparam logic [RAM_AW-1:0] RAM_B3 = 9'h10B;
  localparam logic [RAM_AW-1:0] RAM_B3G = 9'h15B;
  localparam logic [DADDR_W-1:0] B0_GPR = 9'h020;
  localparam logic [DADDR_W-1:0] B1_GPR = 9'h0A0;
  localparam logic [DADDR_W-1:0] B2_GPR = 9'h120;
  localparam logic [DADDR_W-1:0] B2_GPR_LO = 9'h115;
  localparam logic [DADDR_W-1:0] B3_GPR = 9'h1A0;
  localparam logic [DADDR_W-1:0] B3_GPR_LO = 9'h190;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {ACC_NONE = 2'b00, ACC_SFR = 2'b01, ACC_RAM = 2'b11} acc_kind_t;
endpackage

// ### common/ram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ram_if;
  logic we;
  logic [memmap_pkg::RAM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### core/gp_ram.sv
`timescale 1ns/1ps
`default_nettype none
module gp_ram (
  input wire logic clk,
  ram_if.mem port
);
  import memmap_pkg::*;
  logic [7:0] mem_reg [RAM_DEPTH];
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_reg[port.addr] <= port.wdata;
    end
  end
  assign port.rdata = (int'(port.addr) < RAM_DEPTH) ? mem_reg[port.addr] : ZERO_BYTE;
endmodule
`default_nettype wire

// ### core/banked_data_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_map (
  input wire logic clk,
  input wire logic rst,
  input wire logic pc_load,
  input wire logic [memmap_pkg::PC_W-1:0] pc_load_val,
  input wire logic pc_inc,
  input wire logic irq_take,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic acc_indirect,
  input wire logic [memmap_pkg::OFS_W-1:0] acc_ofs,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic [memmap_pkg::PC_W-1:0] pc,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output logic [memmap_pkg::DADDR_W-1:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic [7:0] indirect_pointer,
  output logic bank_sel_lo,
  output logic bank_sel_hi
);
  import memmap_pkg::*;

  // ************************************************************
  // Program counter
  // ************************************************************
  logic [PC_W-1:0] pc_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_reg <= RESET_VEC;
    end else if (irq_take) begin
      pc_reg <= INT_VEC;
    end else if (pc_load) begin
      pc_reg <= pc_load_val;
    end else if (pc_inc) begin
      pc_reg <= pc_reg + PC_W'(1);
    end
  end
  assign pc = pc_reg;

  // ************************************************************
  // Address formation and decode
  // ************************************************************
  logic bank_lo_reg;
  logic bank_hi_reg;
  logic [7:0] ptr_reg;
  logic [DADDR_W-1:0] daddr;
  logic [OFS_W-1:0] ofs;
  logic [DADDR_W-1:0] maddr;
  acc_kind_t kind;
  logic [RAM_AW-1:0] ram_idx;

  // Indirect uses the pointer's eight bits with the high bank bit as top bit.
  always_comb begin
    if (acc_indirect && acc_ofs != OFS_INDIRECT) begin
      daddr = {bank_hi_reg, bank_lo_reg, acc_ofs};
    end else if (acc_indirect) begin
      daddr = {bank_hi_reg, ptr_reg};
    end else begin
      daddr = {bank_hi_reg, bank_lo_reg, acc_ofs};
    end
  end
  assign ofs = daddr[OFS_W-1:0];

  always_comb begin
    kind = ACC_NONE;
    ram_idx = RAM_B0;
    maddr = daddr;
    if (ofs >= SHARED_LO) begin
      kind = ACC_RAM;
      ram_idx = RAM_AW'(ofs - SHARED_LO) + RAM_B0 + RAM_AW'(SHARED_LO - OFS_W'(B0_GPR));
    end else if (ofs <= SFR_LAST && !(daddr > B2_SFR_END && daddr < B2_GPR)
        && !(daddr >= B3_GPR_LO && daddr < B3_GPR)) begin
      // Banks 2 and 3 hold general RAM in the upper part of the special range.
      kind = ACC_SFR;
      if (daddr[DADDR_W-1:OFS_W] == 2'b10 && ofs == OFS_TIMER) begin
        maddr = {2'b00, ofs};
      end
      if (ofs == OFS_STATUS || ofs == OFS_POINTER || ofs == OFS_PCL || ofs == OFS_PCLATH
          || ofs == OFS_INTCON) begin
        maddr = {2'b00, ofs};
      end
      if (daddr == B3_OPTION) begin
        maddr = B1_OPTION;
      end
      if (daddr >= B3_GAP_LO && daddr < B3_GPR_LO) begin
        kind = ACC_NONE;
      end
    end else begin
      unique case (daddr[DADDR_W-1:OFS_W])
        2'b00: begin
          kind = ACC_RAM;
          ram_idx = RAM_B0 + RAM_AW'(daddr - B0_GPR);
        end
        2'b01: begin
          kind = ACC_RAM;
          ram_idx = RAM_B1 + RAM_AW'(daddr - B1_GPR);
        end
        2'b10: begin
          if (daddr <= B2_SFR_END) begin
            kind = ACC_SFR;
          end else if (daddr < B2_GPR) begin
            kind = ACC_RAM;
            ram_idx = RAM_B2G + RAM_AW'(daddr - B2_GPR_LO);
          end else begin
            kind = ACC_RAM;
            ram_idx = RAM_B2 + RAM_AW'(daddr - B2_GPR);
          end
        end
        2'b11: begin
          if (daddr < B3_GPR_LO) begin
            kind = ACC_NONE;
          end else if (daddr < B3_GPR) begin
            kind = ACC_RAM;
            ram_idx = RAM_B3G + RAM_AW'(daddr - B3_GPR_LO);
          end else begin
            kind = ACC_RAM;
            ram_idx = RAM_B3 + RAM_AW'(daddr - B3_GPR);
          end
        end
      endcase
    end
  end

  // ************************************************************
  // General RAM
  // ************************************************************
  ram_if ram ();
  assign ram.we = acc_wr && kind == ACC_RAM;
  assign ram.addr = ram_idx;
  assign ram.wdata = acc_wdata;
  gp_ram u_ram (
    .clk(clk),
    .port(ram)
  );

  // ************************************************************
  // Core registers
  // ************************************************************
  logic hit_status;
  logic hit_ptr;
  assign hit_status = kind == ACC_SFR && maddr == {2'b00, OFS_STATUS};
  assign hit_ptr = kind == ACC_SFR && maddr == {2'b00, OFS_POINTER};

  always_ff @(posedge clk) begin
    if (rst) begin
      bank_lo_reg <= 1'b0;
      bank_hi_reg <= 1'b0;
    end else if (acc_wr && hit_status) begin
      bank_lo_reg <= acc_wdata[STATUS_LO_BIT];
      bank_hi_reg <= acc_wdata[STATUS_HI_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= ZERO_BYTE;
    end else if (acc_wr && hit_ptr) begin
      ptr_reg <= acc_wdata;
    end
  end
  assign indirect_pointer = ptr_reg;
  assign bank_sel_lo = bank_lo_reg;
  assign bank_sel_hi = bank_hi_reg;

  // ************************************************************
  // Peripheral strobes and read return
  // ************************************************************
  // Strobes are registered so every output leaves a flip-flop; peripherals see them
  // one cycle after the request.
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_addr <= '0;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_wdata <= ZERO_BYTE;
    end else begin
      sfr_addr <= maddr;
      sfr_wr <= acc_wr && kind == ACC_SFR && !hit_status && !hit_ptr;
      sfr_rd <= acc_rd && kind == ACC_SFR && !hit_status && !hit_ptr;
      sfr_wdata <= acc_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_rdata <= ZERO_BYTE;
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= acc_rd;
      if (!acc_rd || kind == ACC_NONE) begin
        acc_rdata <= ZERO_BYTE;
      end else if (kind == ACC_RAM) begin
        acc_rdata <= ram.rdata;
      end else if (hit_ptr) begin
        acc_rdata <= ptr_reg;
      end else if (hit_status) begin
        acc_rdata <= {1'b0, bank_hi_reg, bank_lo_reg, 5'h00};
      end else begin
        acc_rdata <= sfr_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Peripheral register model.
// ****
module periph_model (
  input wire logic [memmap_pkg::OFS_W-1:0] acc_ofs,
  output logic [7:0] sfr_rdata
);
  // A marked pattern, so a read served from RAM by mistake cannot match.
  assign sfr_rdata = {1'b1, acc_ofs};
endmodule
`default_nettype wire

// ### tb/memmap_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks.
// ****
module memmap_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic pc_load,
  input wire logic [memmap_pkg::PC_W-1:0] pc_load_val,
  input wire logic pc_inc,
  input wire logic irq_take,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic acc_indirect,
  input wire logic [memmap_pkg::OFS_W-1:0] acc_ofs,
  input wire logic [7:0] acc_wdata,
  input wire logic [memmap_pkg::PC_W-1:0] pc,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic [7:0] indirect_pointer,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi
);
  import memmap_pkg::*;
  default clocking cb @(posedge clk); endclocking
  reset_vec_a: assert property (rst |=> pc == RESET_VEC)
    else $error("pc not at reset vector");
  irq_vec_a: assert property (disable iff (rst) irq_take |=> pc == INT_VEC)
    else $error("pc not at interrupt vector");
  pc_step_a: assert property (disable iff (rst)
    pc_inc && !pc_load && !irq_take |=> pc == $past(pc) + 13'h0001)
    else $error("pc did not step");
  pc_load_a: assert property (disable iff (rst)
    pc_load && !pc_inc && !irq_take |=> pc == $past(pc_load_val))
    else $error("pc did not load");
  read_valid_a: assert property (disable iff (rst) acc_rvalid == $past(acc_rd))
    else $error("read valid misplaced");
  bank_write_a: assert property (disable iff (rst)
    acc_wr && !acc_indirect && acc_ofs == OFS_STATUS
    |=> {bank_sel_hi, bank_sel_lo} == $past(acc_wdata[6:5]))
    else $error("bank bits not written");
  pointer_write_a: assert property (disable iff (rst)
    acc_wr && acc_ofs == OFS_POINTER |=> indirect_pointer == $past(acc_wdata))
    else $error("pointer not written");
  gap_zero_a: assert property (disable iff (rst)
    acc_rd && !acc_indirect && bank_sel_hi && bank_sel_lo
    && acc_ofs inside {[7'h0D:7'h0F]} |=> acc_rdata == 8'h00)
    else $error("gap read not zero");
endmodule
bind banked_data_memory_map memmap_props u_props (.clk, .rst, .pc_load, .pc_load_val,
  .pc_inc, .irq_take, .acc_rd, .acc_wr, .acc_indirect, .acc_ofs, .acc_wdata, .pc,
  .acc_rdata, .acc_rvalid, .indirect_pointer, .bank_sel_lo, .bank_sel_hi);
`default_nettype wire

// ### tb/test_banked_data_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench.
// ****
module test_banked_data_memory_map;
  import memmap_pkg::*;
  logic clk, rst, pc_load, pc_inc, irq_take, acc_rd, acc_wr, acc_indirect;
  logic acc_rvalid, sfr_wr, sfr_rd, bank_sel_lo, bank_sel_hi;
  logic [PC_W-1:0] pc_load_val, pc;
  logic [OFS_W-1:0] acc_ofs;
  logic [7:0] acc_wdata, sfr_rdata, acc_rdata, sfr_wdata, indirect_pointer;
  logic [DADDR_W-1:0] sfr_addr;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  banked_data_memory_map u_dut (.clk, .rst, .pc_load, .pc_load_val, .pc_inc, .irq_take,
    .acc_rd, .acc_wr, .acc_indirect, .acc_ofs, .acc_wdata, .sfr_rdata, .pc, .acc_rdata,
    .acc_rvalid, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .indirect_pointer,
    .bank_sel_lo, .bank_sel_hi);
  periph_model u_periph (.acc_ofs, .sfr_rdata);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // The whole run needs well under 200 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic check(string what, logic [12:0] exp, logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(logic wr, logic ind, logic [6:0] ofs, logic [7:0] d);
    @(posedge clk);
    #1;
    {acc_wr, acc_rd, acc_indirect, acc_ofs, acc_wdata} = {wr, !wr, ind, ofs, d};
    @(posedge clk);
    #1;
    {acc_wr, acc_rd} = 2'b00;
  endtask
  task automatic rd(logic ind, logic [6:0] ofs, logic [7:0] exp);
    acc(1'b0, ind, ofs, 8'h00);
    check("rvalid", 13'h1, {12'h0, acc_rvalid});
    check("rdata", {5'h0, exp}, {5'h0, acc_rdata});
  endtask
  task automatic bank(logic [1:0] b);
    acc(1'b1, 1'b0, OFS_STATUS, {1'b0, b, 5'h00});
    check("bank", {11'h0, b}, {11'h0, bank_sel_hi, bank_sel_lo});
  endtask
  task automatic test_pc();
    check("pc", RESET_VEC, pc);
    pc_inc = 1;
    repeat (3) @(posedge clk);
    #1 pc_inc = 0;
    check("pc", 13'h0003, pc);
    irq_take = 1;
    @(posedge clk);
    #1 {irq_take, pc_load, pc_load_val} = {2'b01, 13'h1FFF};
    check("pc", INT_VEC, pc);
    @(posedge clk);
    #1 {pc_load, pc_inc} = 2'b01;
    check("pc", 13'h1FFF, pc);
    @(posedge clk);
    #1 pc_inc = 0;
    check("pc", 13'h0000, pc);
    $display("test pc done");
  endtask
  task automatic test_data();
    for (int b = 0; b < 4; b++) begin
      bank(b[1:0]);
      acc(1'b1, 1'b0, 7'h25, 8'h30 + b[7:0]);
    end
    for (int b = 3; b >= 0; b--) begin
      bank(b[1:0]);
      rd(1'b0, 7'h25, 8'h30 + b[7:0]);
    end
    acc(1'b1, 1'b0, OFS_POINTER, 8'hA5);
    check("ptr", 13'h0A5, {5'h0, indirect_pointer});
    rd(1'b1, OFS_INDIRECT, 8'h31);
    rd(1'b0, OFS_POINTER, 8'hA5);
    rd(1'b0, 7'h05, 8'h85);
    check("sfr_rd", 13'h1, {12'h0, sfr_rd});
    check("sfr_addr", 13'h005, {4'h0, sfr_addr});
    acc(1'b1, 1'b0, 7'h05, 8'h3C);
    check("sfr_wr", 13'h1, {12'h0, sfr_wr});
    check("sfr_wdata", 13'h03C, {5'h0, sfr_wdata});
    bank(2'b10);
    acc(1'b1, 1'b0, 7'h15, 8'h77);
    rd(1'b0, 7'h15, 8'h77);
    bank(2'b11);
    acc(1'b1, 1'b0, 7'h10, 8'h66);
    rd(1'b0, 7'h10, 8'h66);
    rd(1'b0, OFS_STATUS, 8'h60);
    acc(1'b1, 1'b0, 7'h7F, 8'h5A);
    acc(1'b1, 1'b0, 7'h0D, 8'hFF);
    rd(1'b0, 7'h0D, 8'h00);
    bank(2'b00);
    rd(1'b0, 7'h7F, 8'h5A);
    $display("test data done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {rst, pc_load, pc_inc, irq_take, acc_rd, acc_wr, acc_indirect} = 7'b1000000;
    {pc_load_val, acc_ofs, acc_wdata} = '0;
    repeat (5) @(posedge clk);
    #1 rst = 0;
    test_pc();
    test_data();
    end_of_test();
  end
endmodule
`default_nettype wire
